// ==== include/charge_defs.svh ====
// constant offsets, field positions, reset values and timing counts of the charge indicator
`ifndef CHARGE_DEFS_SVH
`define CHARGE_DEFS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFS_NOMINAL      6'h00
`define OFS_UV_RAW       6'h04
`define OFS_RESET_CELL   6'h08
`define OFS_FULL_CELL    6'h0C
`define OFS_EMPTY_CELL   6'h10
`define OFS_DRAIN_TIME   6'h14
`define OFS_CEILING      6'h18
`define OFS_STATUS       6'h1C
`define OFS_UV_LEVEL     6'h20
`define OFS_SOC_LEVEL    6'h24

// ----------------------------------------------------------------
// status register field positions
// ----------------------------------------------------------------
`define ST_PCT_LSB       0
`define ST_STATE_LSB     8
`define ST_BELOW_BIT     16
`define ST_CUTBACK_BIT   17

// ----------------------------------------------------------------
// reset values and setting limits
// ----------------------------------------------------------------
`define RST_NOMINAL_V    8'h18
`define RST_UV_RAW       8'h80
`define RST_RESET_CELL   12'h82A
`define RST_FULL_CELL    12'h7F8
`define RST_EMPTY_CELL   12'h6C2
`define RST_DRAIN_TIME   10'h01E
`define RST_CEILING      7'h5A
`define UV_RAW_MIN       8'h80
`define UV_RAW_MAX       8'hCC
`define CELL_MV_MIN      12'h384
`define CELL_MV_MAX      12'hBB8
`define DRAIN_MAX        10'h258
`define PCT_FULL         7'h64
`define MV_PER_VOLT      10'h3E8
`define CELLS_SHIFT      1
`define MIN_VOLT_MV      20'h041A0

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS    10
`define MS_TIME_NS       1000000
`define MS_PER_MIN       60000
`define DRAIN_DIVISOR    100

`endif

// ==== include/charge_pkg.sv ====
// types shared by the charge indicator modules
package charge_pkg;

	// ----------------------------------------------------------------
	// voltages are carried in millivolts
	// ----------------------------------------------------------------
	localparam int VOLT_W = 20;
	typedef logic [VOLT_W-1:0] volt_t;

	// software settings
	typedef struct packed {
		logic [7:0]  nominal_v;       // nominal pack voltage in volts
		logic [7:0]  uv_raw;          // undervoltage fraction, n/256 of nominal
		logic [11:0] reset_cell_voltage;
		logic [11:0] full_cell_voltage;
		logic [11:0] empty_cell_voltage;
		logic [9:0]  drain_time_setting; // minutes
		logic [6:0]  restore_percent_ceiling;
	} cfg_t;

	// derived pack levels
	typedef struct packed {
		logic [6:0] cells;
		volt_t      reset_lvl;
		volt_t      full_lvl;
		volt_t      empty_lvl;
		volt_t      soc_lvl;
		volt_t      uv_lvl;
	} levels_t;

	// nonvolatile write strobe with its data
	typedef struct packed {
		logic       wr;
		logic [6:0] percent;
	} nv_wr_t;

	// session sequencing
	typedef enum logic [3:0] {
		ST_OFF   = 4'h1,
		ST_LOAD  = 4'h2,
		ST_CHECK = 4'h4,
		ST_RUN   = 4'h8
	} session_t;

endpackage : charge_pkg

// ==== design/charge_level_calc.sv ====
// pack level arithmetic: cell count, reset/full/empty/charge levels and undervoltage threshold
`timescale 1ns/1ns
`default_nettype none
`include "charge_defs.svh"

module charge_level_calc (
	input  wire logic              core_clk,
	input  wire logic              rst,
	input  wire charge_pkg::cfg_t  cfg,
	input  wire logic [6:0]        charge_percent,
	output var  charge_pkg::levels_t levels
);
	import charge_pkg::*;

	// ----------------------------------------------------------------
	// combinational math, registered once
	// ----------------------------------------------------------------
	levels_t     nxt_levels;       // next derived levels
	levels_t     levels_ff;        // registered levels
	logic [17:0] nominal_mv;       // nominal voltage in mv
	logic [25:0] uv_prod;          // nominal mv times fraction
	volt_t       uv_frac;          // user threshold before floor
	volt_t       span;             // full minus empty, never negative
	logic [26:0] span_prod;        // span times percent

	// one cycle of latency keeps the multipliers off the state path
	always_comb begin
		nxt_levels           = levels_ff;
		nxt_levels.cells     = 7'(cfg.nominal_v >> `CELLS_SHIFT);
		nxt_levels.reset_lvl = VOLT_W'(cfg.reset_cell_voltage * nxt_levels.cells);
		nxt_levels.full_lvl  = VOLT_W'(cfg.full_cell_voltage * nxt_levels.cells);
		nxt_levels.empty_lvl = VOLT_W'(cfg.empty_cell_voltage * nxt_levels.cells);
		nominal_mv           = 18'(cfg.nominal_v * `MV_PER_VOLT);
		uv_prod              = 26'(nominal_mv * cfg.uv_raw);
		uv_frac              = VOLT_W'(uv_prod >> 8);
		// the floor keeps the threshold at or above the power stage minimum
		nxt_levels.uv_lvl    = (uv_frac > `MIN_VOLT_MV) ? uv_frac : `MIN_VOLT_MV;
		// a misconfigured full below empty collapses to a flat level
		span                 = (nxt_levels.full_lvl > nxt_levels.empty_lvl) ?
		                       VOLT_W'(nxt_levels.full_lvl - nxt_levels.empty_lvl) : '0;
		span_prod            = 27'(span * charge_percent);
		nxt_levels.soc_lvl   = VOLT_W'(nxt_levels.empty_lvl + VOLT_W'(span_prod / `PCT_FULL));
	end

	// register stage
	always_ff @(posedge core_clk) begin
		if (rst) begin
			levels_ff <= '{cells: 7'h00, reset_lvl: '0, full_lvl: '0, empty_lvl: '0,
			               soc_lvl: '0, uv_lvl: `MIN_VOLT_MV};
		end else begin
			levels_ff <= nxt_levels;
		end
	end

	assign levels = levels_ff;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	property p_cells;
		$stable(cfg) ##1 $stable(cfg) |-> levels.cells == 7'(cfg.nominal_v / 2);
	endproperty
	a_cells: assert property (p_cells) else $error("cell count is not half the nominal");

	property p_full_level;
		$stable(cfg) ##1 $stable(cfg) |-> levels.full_lvl == VOLT_W'(cfg.full_cell_voltage * levels.cells);
	endproperty
	a_full_level: assert property (p_full_level) else $error("full level wrong");

	property p_uv_floor;
		levels.uv_lvl >= `MIN_VOLT_MV;
	endproperty
	a_uv_floor: assert property (p_uv_floor) else $error("threshold below minimum");

endmodule : charge_level_calc
`default_nettype wire

// ==== design/charge_indicator.sv ====
// battery charge indicator: settings registers, session sequencing and discharge integration
`timescale 1ns/1ns
`default_nettype none
`include "charge_defs.svh"

module charge_indicator #(
	parameter int MS_CYCLES = `MS_TIME_NS / `CLK_PERIOD_NS   // core clocks per millisecond
) (
	input  wire logic                  core_clk,
	input  wire logic                  rst,
	input  wire logic [5:0]            avs_address,
	input  wire logic                  avs_read,
	input  wire logic                  avs_write,
	input  wire logic [31:0]           avs_writedata,
	output var  logic [31:0]           avs_readdata,
	output var  logic                  avs_waitrequest,
	input  wire logic                  key_switch_input,
	input  wire charge_pkg::volt_t     key_voltage,
	input  wire logic [6:0]            nv_stored_percent,
	output var  charge_pkg::nv_wr_t    nv_write,
	output var  logic [6:0]            charge_percent,
	output var  logic                  drive_cutback
);
	import charge_pkg::*;

	localparam int          MS_W        = $clog2(MS_CYCLES + 1);
	localparam int          BELOW_W     = 20;
	localparam logic [9:0]  MS_PER_UNIT = 10'(`MS_PER_MIN / `DRAIN_DIVISOR);

	// ----------------------------------------------------------------
	// avalon slave: one wait cycle, then the answer
	// ----------------------------------------------------------------
	logic        ack_ff;          // high in the cycle the request completes
	logic        nxt_ack;
	logic [31:0] rdata_ff;        // read data captured in the wait cycle
	logic [31:0] nxt_rdata;
	cfg_t        cfg_ff;          // software settings
	cfg_t        nxt_cfg;
	levels_t     levels;          // derived levels
	session_t    state_ff;        // session sequencing
	session_t    nxt_state;
	logic [6:0]  charge_ff;       // charge percent
	logic [6:0]  nxt_charge;
	logic        below_now;       // filtered voltage under charge level

	// clamp a 12-bit value into a range
	function automatic logic [11:0] clamp12(input logic [11:0] v, input logic [11:0] lo, input logic [11:0] hi);
		clamp12 = (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction : clamp12

	// ack, read mux and setting writes
	always_comb begin
		nxt_ack   = (avs_read | avs_write) & ~ack_ff;
		nxt_rdata = rdata_ff;
		nxt_cfg   = cfg_ff;
		if (avs_read && !ack_ff) begin
			case (avs_address)
				`OFS_NOMINAL:    nxt_rdata = {24'h000000, cfg_ff.nominal_v};
				`OFS_UV_RAW:     nxt_rdata = {24'h000000, cfg_ff.uv_raw};
				`OFS_RESET_CELL: nxt_rdata = {20'h00000, cfg_ff.reset_cell_voltage};
				`OFS_FULL_CELL:  nxt_rdata = {20'h00000, cfg_ff.full_cell_voltage};
				`OFS_EMPTY_CELL: nxt_rdata = {20'h00000, cfg_ff.empty_cell_voltage};
				`OFS_DRAIN_TIME: nxt_rdata = {22'h000000, cfg_ff.drain_time_setting};
				`OFS_CEILING:    nxt_rdata = {25'h0000000, cfg_ff.restore_percent_ceiling};
				`OFS_STATUS: begin
					nxt_rdata                                  = 32'h00000000;
					nxt_rdata[`ST_PCT_LSB +: 7]                = charge_ff;
					nxt_rdata[`ST_STATE_LSB +: 4]              = state_ff;
					nxt_rdata[`ST_BELOW_BIT]                   = below_now;
					nxt_rdata[`ST_CUTBACK_BIT]                 = drive_cutback;
				end
				`OFS_UV_LEVEL:   nxt_rdata = {12'h000, levels.uv_lvl};
				`OFS_SOC_LEVEL:  nxt_rdata = {12'h000, levels.soc_lvl};
				default:         nxt_rdata = 32'h00000000;  // unmapped reads as zero
			endcase
		end
		// writes land on the completing edge; out-of-range settings are clamped
		if (avs_write && ack_ff) begin
			case (avs_address)
				`OFS_NOMINAL:    nxt_cfg.nominal_v = avs_writedata[7:0];
				`OFS_UV_RAW:     nxt_cfg.uv_raw = 8'(clamp12({4'h0, avs_writedata[7:0]},
				                                  {4'h0, `UV_RAW_MIN}, {4'h0, `UV_RAW_MAX}));
				`OFS_RESET_CELL: nxt_cfg.reset_cell_voltage = clamp12(avs_writedata[11:0], `CELL_MV_MIN, `CELL_MV_MAX);
				`OFS_FULL_CELL:  nxt_cfg.full_cell_voltage  = clamp12(avs_writedata[11:0], `CELL_MV_MIN, `CELL_MV_MAX);
				`OFS_EMPTY_CELL: nxt_cfg.empty_cell_voltage = clamp12(avs_writedata[11:0], `CELL_MV_MIN, `CELL_MV_MAX);
				`OFS_DRAIN_TIME: nxt_cfg.drain_time_setting = 10'(clamp12({2'h0, avs_writedata[9:0]},
				                                              12'h000, {2'h0, `DRAIN_MAX}));
				`OFS_CEILING:    nxt_cfg.restore_percent_ceiling = 7'(clamp12({5'h00, avs_writedata[6:0]},
				                                                   12'h000, {5'h00, `PCT_FULL}));
				default:         nxt_cfg = cfg_ff;          // read-only or unmapped: ignored
			endcase
		end
	end

	// bus registers
	always_ff @(posedge core_clk) begin
		if (rst) begin
			ack_ff   <= 1'b0;
			rdata_ff <= 32'h00000000;
			cfg_ff   <= '{nominal_v: `RST_NOMINAL_V, uv_raw: `RST_UV_RAW,
			              reset_cell_voltage: `RST_RESET_CELL, full_cell_voltage: `RST_FULL_CELL,
			              empty_cell_voltage: `RST_EMPTY_CELL, drain_time_setting: `RST_DRAIN_TIME,
			              restore_percent_ceiling: `RST_CEILING};
		end else begin
			ack_ff   <= nxt_ack;
			rdata_ff <= nxt_rdata;
			cfg_ff   <= nxt_cfg;
		end
	end

	assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;
	assign avs_readdata    = rdata_ff;

	// ----------------------------------------------------------------
	// level arithmetic
	// ----------------------------------------------------------------
	charge_level_calc u_calc (
		.core_clk       (core_clk),
		.rst            (rst),
		.cfg            (cfg_ff),
		.charge_percent (charge_ff),
		.levels         (levels)
	);

	// ----------------------------------------------------------------
	// millisecond tick and below-level integrator
	// ----------------------------------------------------------------
	logic [MS_W-1:0]    ms_cnt_ff;     // prescaler
	logic [MS_W-1:0]    nxt_ms_cnt;
	logic               ms_tick;       // one cycle per millisecond
	logic [BELOW_W-1:0] below_ms_ff;   // accumulated ms under the level
	logic [BELOW_W-1:0] nxt_below_ms;
	logic [BELOW_W-1:0] limit_ms;      // drain time / 100, in ms
	logic               over_limit;

	assign below_now  = key_voltage < levels.soc_lvl;
	assign limit_ms   = BELOW_W'(cfg_ff.drain_time_setting * MS_PER_UNIT);
	assign over_limit = below_ms_ff > limit_ms;
	assign ms_tick    = ms_cnt_ff == MS_W'(MS_CYCLES - 1);

	// ----------------------------------------------------------------
	// session sequencing and percentage
	// ----------------------------------------------------------------
	logic   nxt_cutback;
	logic   cutback_ff;
	nv_wr_t nxt_nv;
	nv_wr_t nv_ff;

	// the reset comparison lives only in the check state, entered once per power-on
	always_comb begin
		nxt_state    = state_ff;
		nxt_charge   = charge_ff;
		nxt_nv       = '{wr: 1'b0, percent: nv_ff.percent};
		nxt_ms_cnt   = ms_tick ? '0 : MS_W'(ms_cnt_ff + 1'b1);
		nxt_below_ms = below_ms_ff;
		nxt_cutback  = key_voltage < levels.uv_lvl;
		case (state_ff)
			ST_OFF: begin
				// keyswitch off: percentage frozen, integrator idle
				nxt_ms_cnt = '0;
				if (key_switch_input) begin
					nxt_state = ST_LOAD;
				end
			end
			ST_LOAD: begin
				// pick up the stored value; a corrupt value above full saturates
				nxt_charge = (nv_stored_percent > `PCT_FULL) ? `PCT_FULL : nv_stored_percent;
				nxt_state  = ST_CHECK;
			end
			ST_CHECK: begin
				if (key_voltage > levels.reset_lvl && charge_ff < cfg_ff.restore_percent_ceiling) begin
					nxt_charge = `PCT_FULL;
				end
				nxt_below_ms = '0;
				nxt_state    = ST_RUN;
			end
			ST_RUN: begin
				if (!key_switch_input) begin
					// keyswitch released: commit the percentage to storage
					nxt_nv    = '{wr: 1'b1, percent: charge_ff};
					nxt_state = ST_OFF;
				end else if (ms_tick) begin
					if (over_limit) begin
						// step down, never past zero, and restart the integration
						nxt_charge   = (charge_ff != 7'h00) ? 7'(charge_ff - 1'b1) : 7'h00;
						nxt_below_ms = '0;
					end else if (below_now && below_ms_ff != '1) begin
						nxt_below_ms = BELOW_W'(below_ms_ff + 1'b1);
					end
				end
			end
			default: begin
				nxt_state = ST_OFF;
			end
		endcase
	end

	// session registers
	always_ff @(posedge core_clk) begin
		if (rst) begin
			state_ff    <= ST_OFF;
			charge_ff   <= 7'h00;
			nv_ff       <= '{wr: 1'b0, percent: 7'h00};
			ms_cnt_ff   <= '0;
			below_ms_ff <= '0;
			cutback_ff  <= 1'b0;
		end else begin
			state_ff    <= nxt_state;
			charge_ff   <= nxt_charge;
			nv_ff       <= nxt_nv;
			ms_cnt_ff   <= nxt_ms_cnt;
			below_ms_ff <= nxt_below_ms;
			cutback_ff  <= nxt_cutback;
		end
	end

	assign nv_write       = nv_ff;
	assign charge_percent = charge_ff;
	assign drive_cutback  = cutback_ff;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	sequence s_restore_cond;
		state_ff == ST_CHECK && key_voltage > levels.reset_lvl && charge_ff < cfg_ff.restore_percent_ceiling;
	endsequence

	sequence s_key_release;
		state_ff == ST_RUN && !key_switch_input;
	endsequence

	property p_uv_range;
		cfg_ff.uv_raw >= 8'h80 && cfg_ff.uv_raw <= 8'hCC;
	endproperty
	a_uv_range: assert property (p_uv_range) else $error("undervoltage setting out of range");

	property p_cutback;
		drive_cutback |-> $past(key_voltage) < $past(levels.uv_lvl) && $past(levels.uv_lvl) >= `MIN_VOLT_MV;
	endproperty
	a_cutback: assert property (p_cutback) else $error("cutback without low voltage");

	property p_frozen_off;
		state_ff == ST_OFF ##1 state_ff == ST_OFF |-> $stable(charge_ff);
	endproperty
	a_frozen_off: assert property (p_frozen_off) else $error("percent changed while off");

	property p_save;
		s_key_release |=> nv_write.wr && nv_write.percent == $past(charge_ff) ##1 !nv_write.wr;
	endproperty
	a_save: assert property (p_save) else $error("percent not saved at key off");

	property p_no_rerestore;
		state_ff == ST_RUN && $past(state_ff) == ST_RUN && charge_ff != $past(charge_ff)
			|-> charge_ff == 7'($past(charge_ff) - 1'b1);
	endproperty
	a_no_rerestore: assert property (p_no_rerestore) else $error("percent jumped during session");

	property p_restore;
		s_restore_cond |=> charge_ff == 7'h64 && state_ff == ST_RUN;
	endproperty
	a_restore: assert property (p_restore) else $error("power-on restore missed");

	property p_decrement;
		state_ff == ST_RUN && key_switch_input && ms_tick && over_limit && charge_ff != 7'h00
			|=> charge_ff == 7'($past(charge_ff) - 1'b1) && below_ms_ff == '0;
	endproperty
	a_decrement: assert property (p_decrement) else $error("decrement step wrong");

	property p_zero_hold;
		state_ff == ST_RUN && charge_ff == 7'h00 && key_switch_input |=> charge_ff == 7'h00;
	endproperty
	a_zero_hold: assert property (p_zero_hold) else $error("percent left zero");

	property p_bus_answer;
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
	endproperty
	a_bus_answer: assert property (p_bus_answer) else $error("bus answer late");

endmodule : charge_indicator
`default_nettype wire

// ==== testbench/batt_side_model.sv ====
// far side model: keyswitch, filtered pack voltage and nonvolatile percent store
`timescale 1ns/1ns
`default_nettype none

module batt_side_model (
	input  wire logic               core_clk,
	input  wire charge_pkg::nv_wr_t nv_write,
	output var  logic               key_switch_input,
	output var  charge_pkg::volt_t  key_voltage,
	output var  logic [6:0]         nv_stored_percent
);
	import charge_pkg::*;

	// ----------------------------------------------------------------
	// power-up state: key off, pack dead, store empty
	// ----------------------------------------------------------------
	initial begin
		key_switch_input  = 1'b0;
		key_voltage       = 20'h00000;
		nv_stored_percent = 7'h00;
	end

	// the store keeps whatever percent the block saves at power-off
	always @(posedge core_clk) begin
		if (nv_write.wr === 1'b1) begin
			nv_stored_percent <= nv_write.percent;
		end
	end

	// ----------------------------------------------------------------
	// stimulus tasks, each change lands just after an edge
	// ----------------------------------------------------------------
	task automatic power(input logic on, input volt_t mv);
		@(posedge core_clk);
		key_switch_input <= on;
		key_voltage      <= mv;
	endtask : power

	// preload the store as a previous session would have left it
	task automatic store(input logic [6:0] pct);
		@(posedge core_clk);
		nv_stored_percent <= pct;
	endtask : store
endmodule : batt_side_model

`default_nettype wire

// ==== testbench/tb_charge_indicator.sv ====
// self-checking bench for the charge indicator: settings bus, sessions and discharge
`timescale 1ns/1ns
`default_nettype none
`include "charge_defs.svh"

module tb_charge_indicator;
	import charge_pkg::*;

	logic              core_clk = 1'b0;
	logic              rst = 1'b1;
	logic [5:0]        avs_address = 6'h00;
	logic              avs_read = 1'b0;
	logic              avs_write = 1'b0;
	logic [31:0]       avs_writedata;
	logic [31:0]       avs_readdata;
	logic              avs_waitrequest;
	logic              key_switch_input;
	volt_t             key_voltage;
	logic [6:0]        nv_stored_percent;
	nv_wr_t            nv_write;
	logic [6:0]        charge_percent;
	logic              drive_cutback;
	int                n_fail = 0;
	int                n_tests = 0;
	logic [31:0]       rst_tab [7];  // settings reset values, offsets 0x00..0x18

	always #5 core_clk = ~core_clk;

	charge_indicator #(.MS_CYCLES(8)) i_dut (
		.core_clk(core_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .key_switch_input(key_switch_input),
		.key_voltage(key_voltage), .nv_stored_percent(nv_stored_percent), .nv_write(nv_write),
		.charge_percent(charge_percent), .drive_cutback(drive_cutback)
	);

	batt_side_model i_batt (
		.core_clk(core_clk), .nv_write(nv_write), .key_switch_input(key_switch_input),
		.key_voltage(key_voltage), .nv_stored_percent(nv_stored_percent)
	);

	// ----------------------------------------------------------------
	// reporting
	// ----------------------------------------------------------------
	task automatic finish_test();
		$display("checks %0d, mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : finish_test

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
			n_fail++;
		end
	endtask : chk

	// ----------------------------------------------------------------
	// bus access: hold the request until waitrequest is seen low
	// ----------------------------------------------------------------
	task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] wd, output logic [31:0] rd);
		int n;
		n = 0;
		@(posedge core_clk);
		avs_address   <= a;
		avs_writedata <= wd;
		avs_read      <= ~wr;
		avs_write     <= wr;
		@(posedge core_clk);
		// each edge sees the values settled before it; a hung slave must not hang the run
		while (avs_waitrequest !== 1'b0 && n < 20) begin
			@(posedge core_clk);
			n++;
		end
		if (avs_waitrequest !== 1'b0) begin
			n_fail++;
			finish_test();
		end
		rd = avs_readdata;  // taken at the edge that samples waitrequest low
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus

	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		logic [31:0] dummy;
		bus(1'b1, a, d, dummy);
	endtask : wr

	task automatic rdchk(input logic [5:0] a, input logic [31:0] exp);
		logic [31:0] d;
		bus(1'b0, a, 32'h00000000, d);
		chk(d, exp);
	endtask : rdchk

	task automatic idle(input int n);
		repeat (n) @(posedge core_clk);
	endtask : idle

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		rst_tab = '{32'h18, 32'h80, 32'h82A, 32'h7F8, 32'h6C2, 32'h1E, 32'h5A};
		repeat (16) @(posedge core_clk);
		rst <= 1'b0;
		// settings reset values, then an unmapped word
		for (int i = 0; i < 7; i++) begin
			rdchk(6'(i * 4), rst_tab[i]);
		end
		rdchk(6'h3C, 32'h00000000);
		// undervoltage: floor wins at 50 percent, fraction wins at 80 percent
		rdchk(`OFS_UV_LEVEL, 32'h041A0);
		wr(`OFS_UV_RAW, 32'hFF);
		rdchk(`OFS_UV_RAW, 32'hCC);
		rdchk(`OFS_UV_LEVEL, 32'h04AB5);
		wr(`OFS_UV_RAW, 32'h40);
		rdchk(`OFS_UV_RAW, 32'h80);
		// empty level at 0 percent for 12, 12 and 24 cells
		rdchk(`OFS_SOC_LEVEL, 32'h05118);
		wr(`OFS_NOMINAL, 32'h19);
		idle(3);
		rdchk(`OFS_SOC_LEVEL, 32'h05118);
		wr(`OFS_NOMINAL, 32'h30);
		idle(3);
		rdchk(`OFS_SOC_LEVEL, 32'h0A230);
		wr(`OFS_NOMINAL, 32'h18);
		// cutback follows the threshold even with the key off
		i_batt.power(1'b0, 20'd16000);
		idle(3);
		chk({31'h0, drive_cutback}, 32'h1);
		i_batt.power(1'b0, 20'd16800);
		idle(3);
		chk({31'h0, drive_cutback}, 32'h0);
		// reset-level defaults sit above full, as software must keep them
		i_batt.store(7'd50);
		i_batt.power(1'b1, 20'd25081);
		idle(6);
		chk({25'h0, charge_percent}, 32'd100);
		rdchk(`OFS_SOC_LEVEL, 32'd24480);
		i_batt.power(1'b0, 20'd25081);
		idle(4);
		chk({25'h0, nv_stored_percent}, 32'd100);
		// exactly at the reset level: no restore, and a later rise is ignored
		i_batt.store(7'd50);
		i_batt.power(1'b1, 20'd25080);
		idle(6);
		chk({25'h0, charge_percent}, 32'd50);
		i_batt.power(1'b1, 20'd26000);
		idle(20);
		chk({25'h0, charge_percent}, 32'd50);
		i_batt.power(1'b0, 20'd26000);
		// let the power-off save land before the store is preloaded
		idle(3);
		// stored percent at the ceiling blocks the restore
		i_batt.store(7'd90);
		i_batt.power(1'b1, 20'd26000);
		idle(6);
		chk({25'h0, charge_percent}, 32'd90);
		i_batt.power(1'b0, 20'd26000);
		// one-minute drain time: more than 600 ms below the level per percent
		wr(`OFS_DRAIN_TIME, 32'h1);
		i_batt.store(7'd50);
		i_batt.power(1'b1, 20'd20000);
		idle(4500);
		chk({25'h0, charge_percent}, 32'd50);
		idle(600);
		chk({25'h0, charge_percent}, 32'd49);
		rdchk(`OFS_SOC_LEVEL, 32'd22582);
		// zero drain time runs the percent down and holds it at zero
		wr(`OFS_DRAIN_TIME, 32'h0);
		idle(1200);
		chk({25'h0, charge_percent}, 32'd0);
		rdchk(`OFS_SOC_LEVEL, 32'd20760);
		rdchk(`OFS_STATUS, 32'h00010800);
		i_batt.power(1'b0, 20'd20000);
		// let the power-off save land before the store is preloaded
		idle(3);
		// key off before the first decrement: value saved, then frozen
		i_batt.store(7'd60);
		i_batt.power(1'b1, 20'd20000);
		idle(5);
		i_batt.power(1'b0, 20'd20000);
		idle(4);
		chk({25'h0, nv_stored_percent}, 32'd60);
		idle(100);
		chk({25'h0, charge_percent}, 32'd60);
		finish_test();
	end

	// a stuck sequence still reaches the verdict
	initial begin
		repeat (40000) @(posedge core_clk);
		n_fail++;
		finish_test();
	end
endmodule : tb_charge_indicator

`default_nettype wire
